// [rtl/idech_pkg.sv]
package idech_pkg;
   localparam int CLK_MHZ = 20;
   localparam int T_SETUP_NS = 70;
   localparam int T_ACT_NS = 290;
   localparam int T_REC_NS = 240;
   localparam int T_UDMA_NS = 120;
   localparam int T_STOP_NS = 150;
   localparam logic [3:0] T_SETUP_CYC = 4'((T_SETUP_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] T_ACT_CYC = 4'((T_ACT_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] T_REC_CYC = 4'((T_REC_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] T_UDMA_CYC = 4'((T_UDMA_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] T_STOP_CYC = 4'((T_STOP_NS * CLK_MHZ + 999) / 1000);
   localparam int DATA_W = 16;
   localparam int FIFO_DEPTH = 4;
   localparam logic [12:0] PRI_CMD_BASE = 13'h003e;
   localparam logic [12:0] PRI_CTL_BASE = 13'h007e;
   localparam logic [12:0] SEC_CMD_BASE = 13'h002e;
   localparam logic [12:0] SEC_CTL_BASE = 13'h006e;
   typedef enum logic [2:0] {
      OP_PIO_RD, OP_PIO_WR, OP_DMA_RD, OP_DMA_WR, OP_UDMA_RD, OP_UDMA_WR, OP_UDMA_END
   } idech_op_t;
   typedef struct packed {
      idech_op_t op;
      logic chan;
      logic [15:0] io_addr;
      logic [15:0] wdata;
   } idech_cmd_t;
   typedef struct packed {
      logic cmd_sel_n;
      logic ctl_sel_n;
      logic dmack_n;
      logic rd_n;
      logic wr_n;
      logic [2:0] addr;
      logic [15:0] dout;
      logic doe;
   } idech_pins_t;
   localparam idech_pins_t PINS_IDLE = '{cmd_sel_n: 1'b1, ctl_sel_n: 1'b1, dmack_n: 1'b1,
      rd_n: 1'b1, wr_n: 1'b1, addr: 3'h0, dout: 16'h0000, doe: 1'b0};
endpackage

// [rtl/idech_channel.sv]
`timescale 1ns/1ns
// ****************************************
// read data buffer
// ****************************************
module idech_fifo #(
   parameter int W = 16,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [W-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   always_comb begin
      in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
      out_valid = wr_ptr != rd_ptr;
      out_data = mem[rd_ptr[AW-1:0]];
      next_wr_ptr = wr_ptr + (AW+1)'(in_valid && in_ready);
      next_rd_ptr = rd_ptr + (AW+1)'(out_valid && out_ready);
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
      if (in_valid && in_ready) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end
endmodule // idech_fifo

`timescale 1ns/1ns
// ****************************************
// ide channel pin engine
// ****************************************
module idech_channel (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic split_cfg,
   input wire logic pos,
   input wire idech_pkg::idech_cmd_t cmd,
   input wire logic cmd_valid,
   output logic cmd_ready,
   output logic [15:0] rd_data,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic err,
   output logic busy,
   output logic pri_req_level,
   output logic sec_req_level,
   output logic pri_dma_ack_n,
   input wire logic pri_dma_req,
   output logic pri_read_strobe_n,
   output logic pri_write_strobe_n,
   input wire logic pri_channel_ready,
   input wire logic [15:0] pri_disk_data_in,
   output logic [15:0] pri_disk_data_out,
   output logic pri_disk_data_oe,
   output logic [2:0] pri_disk_addr,
   output logic pri_cmd_block_sel_n,
   output logic pri_ctl_block_sel_n,
   output logic sec_dma_ack_n,
   input wire logic sec_dma_req,
   output logic sec_read_strobe_n,
   output logic sec_write_strobe_n,
   input wire logic sec_channel_ready,
   input wire logic [15:0] sec_disk_data_in,
   output logic [15:0] sec_disk_data_out,
   output logic sec_disk_data_oe,
   output logic [2:0] sec_disk_addr,
   output logic sec_cmd_block_sel_n,
   output logic sec_ctl_block_sel_n,
   output logic sec_ctl_block_sel_oe
);
   typedef enum {S_IDLE, S_SETUP, S_ACT, S_REC, S_URD, S_UWR, S_STOP} idech_state_t;
   idech_state_t state, next_state;
   idech_pkg::idech_pins_t pins [2];
   idech_pkg::idech_pins_t next_pins [2];
   idech_pkg::idech_pins_t p;
   idech_pkg::idech_cmd_t cur, next_cur;
   logic [3:0] cnt, next_cnt;
   logic ch, next_ch, upend, next_upend, next_err;
   logic tgt, hit, pri_cmd_hit, pri_ctl_hit, sec_cmd_hit, sec_ctl_hit;
   logic is_pio, is_rd, push, fifo_in_ready;
   logic [1:0] req_s1, req_s2, rdy_s1, rdy_s2, rdy_s3;
   logic [15:0] din_s1 [2];
   logic [15:0] din_s2 [2];
   logic ready_s, rdy_edge;

   // ****************************************
   // pin synchronisers
   // ****************************************
   // data passes the same two stages as the ready line so an edge and its word line up
   always_ff @(posedge clk) begin
      req_s1 <= {sec_dma_req, pri_dma_req};
      req_s2 <= req_s1;
      rdy_s1 <= {sec_channel_ready, pri_channel_ready};
      rdy_s2 <= rdy_s1;
      rdy_s3 <= rdy_s2;
      din_s1[0] <= pri_disk_data_in;
      din_s1[1] <= sec_disk_data_in;
      din_s2 <= din_s1;
   end
   assign ready_s = rdy_s2[ch];
   assign rdy_edge = rdy_s2[ch] ^ rdy_s3[ch];
   assign pri_req_level = req_s2[0];
   assign sec_req_level = req_s2[1];

   // ****************************************
   // address decode
   // ****************************************
   always_comb begin
      pri_cmd_hit = cmd.io_addr[15:3] == idech_pkg::PRI_CMD_BASE;
      pri_ctl_hit = cmd.io_addr[15:3] == idech_pkg::PRI_CTL_BASE;
      // in split mode the secondary pins belong to the primary slave, so no secondary range
      sec_cmd_hit = !split_cfg && cmd.io_addr[15:3] == idech_pkg::SEC_CMD_BASE;
      sec_ctl_hit = !split_cfg && cmd.io_addr[15:3] == idech_pkg::SEC_CTL_BASE;
      is_pio = cmd.op == idech_pkg::OP_PIO_RD || cmd.op == idech_pkg::OP_PIO_WR;
      hit = pri_cmd_hit || pri_ctl_hit || sec_cmd_hit || sec_ctl_hit;
      if (is_pio) begin
         tgt = sec_cmd_hit || sec_ctl_hit || (split_cfg && cmd.chan);
      end else begin
         tgt = cmd.chan;
      end
      is_rd = cur.op == idech_pkg::OP_PIO_RD || cur.op == idech_pkg::OP_DMA_RD;
   end

   // ****************************************
   // transfer sequencer
   // ****************************************
   always_comb begin
      next_state = state;
      next_pins = pins;
      next_cur = cur;
      next_cnt = cnt;
      next_ch = ch;
      next_upend = upend;
      next_err = 1'b0;
      cmd_ready = 1'b0;
      push = 1'b0;
      p = idech_pkg::PINS_IDLE;
      case (state)
         S_IDLE: begin
            cmd_ready = 1'b1;
            next_pins[0] = idech_pkg::PINS_IDLE;
            next_pins[1] = idech_pkg::PINS_IDLE;
            if (cmd_valid) begin
               next_cur = cmd;
               next_ch = tgt;
               if ((is_pio && !hit) || cmd.op == idech_pkg::OP_UDMA_END) begin
                  next_err = 1'b1;
               end else begin
                  p.addr = cmd.io_addr[2:0];
                  if (is_pio) begin
                     p.cmd_sel_n = !(pri_cmd_hit || sec_cmd_hit);
                     p.ctl_sel_n = !(pri_ctl_hit || sec_ctl_hit);
                  end else begin
                     p.dmack_n = 1'b0;
                  end
                  if (cmd.op == idech_pkg::OP_PIO_WR || cmd.op == idech_pkg::OP_DMA_WR) begin
                     p.dout = cmd.wdata;
                     p.doe = 1'b1;
                  end
                  next_pins[tgt] = p;
                  next_cnt = idech_pkg::T_SETUP_CYC;
                  next_state = S_SETUP;
               end
            end
         end
         S_SETUP: begin
            if (cnt > 4'h1) begin
               next_cnt = cnt - 4'h1;
            end else if (cur.op == idech_pkg::OP_UDMA_RD) begin
               next_state = S_URD;
            end else if (cur.op == idech_pkg::OP_UDMA_WR) begin
               next_pins[ch].doe = 1'b1;
               next_upend = 1'b0;
               next_state = S_UWR;
            end else begin
               // the first word of a dma write rides in with the command
               next_pins[ch].rd_n = !is_rd;
               next_pins[ch].wr_n = is_rd;
               next_cnt = idech_pkg::T_ACT_CYC;
               next_state = S_ACT;
            end
         end
         S_ACT: begin
            if (cnt > 4'h1) begin
               next_cnt = cnt - 4'h1;
            end else if (!pins[ch].dmack_n || ready_s) begin
               if (!is_rd || fifo_in_ready) begin
                  next_pins[ch].rd_n = 1'b1;
                  next_pins[ch].wr_n = 1'b1;
                  push = is_rd;
                  next_cnt = idech_pkg::T_REC_CYC;
                  next_state = S_REC;
               end
            end
         end
         S_REC: begin
            if (cnt > 4'h1) begin
               next_cnt = cnt - 4'h1;
            end else begin
               next_pins[ch] = idech_pkg::PINS_IDLE;
               next_state = S_IDLE;
            end
         end
         S_URD: begin
            // pause reaches the drive some cycles late; a full buffer then drops a word
            next_pins[ch].rd_n = !fifo_in_ready;
            push = rdy_edge;
            cmd_ready = cmd.op == idech_pkg::OP_UDMA_END;
            if (cmd_valid && cmd_ready) begin
               next_pins[ch].wr_n = 1'b0;
               next_cnt = idech_pkg::T_STOP_CYC;
               next_state = S_STOP;
            end
         end
         S_UWR: begin
            cmd_ready = !upend && (cmd.op == idech_pkg::OP_UDMA_WR
                                   || cmd.op == idech_pkg::OP_UDMA_END);
            if (upend) begin
               if (cnt > 4'h1) begin
                  next_cnt = cnt - 4'h1;
               end else if (!ready_s) begin
                  next_pins[ch].rd_n = !pins[ch].rd_n;
                  next_upend = 1'b0;
               end
            end else if (cmd_valid && cmd_ready) begin
               if (cmd.op == idech_pkg::OP_UDMA_WR) begin
                  next_pins[ch].dout = cmd.wdata;
                  next_cnt = idech_pkg::T_UDMA_CYC;
                  next_upend = 1'b1;
               end else begin
                  next_pins[ch].wr_n = 1'b0;
                  next_cnt = idech_pkg::T_STOP_CYC;
                  next_state = S_STOP;
               end
            end
         end
         S_STOP: begin
            if (cnt > 4'h1) begin
               next_cnt = cnt - 4'h1;
            end else begin
               next_pins[ch] = idech_pkg::PINS_IDLE;
               next_state = S_IDLE;
            end
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= S_IDLE;
         pins[0] <= idech_pkg::PINS_IDLE;
         pins[1] <= idech_pkg::PINS_IDLE;
         cur <= '0;
         cnt <= 4'h0;
         ch <= 1'b0;
         upend <= 1'b0;
         err <= 1'b0;
      end else begin
         state <= next_state;
         pins <= next_pins;
         cur <= next_cur;
         cnt <= next_cnt;
         ch <= next_ch;
         upend <= next_upend;
         err <= next_err;
      end
   end

   idech_fifo #(
      .W(idech_pkg::DATA_W),
      .DEPTH(idech_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_data(din_s2[ch]),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .out_data(rd_data),
      .out_valid(rd_valid),
      .out_ready(rd_ready)
   );

   // ****************************************
   // pin outputs
   // ****************************************
   assign busy = state != S_IDLE;
   assign pri_dma_ack_n = pins[0].dmack_n;
   assign pri_read_strobe_n = pins[0].rd_n;
   assign pri_write_strobe_n = pins[0].wr_n;
   assign pri_disk_data_out = pins[0].dout;
   assign pri_disk_data_oe = pins[0].doe;
   assign pri_disk_addr = pins[0].addr;
   assign pri_cmd_block_sel_n = pins[0].cmd_sel_n;
   assign pri_ctl_block_sel_n = pins[0].ctl_sel_n;
   assign sec_dma_ack_n = pins[1].dmack_n;
   assign sec_read_strobe_n = pins[1].rd_n;
   assign sec_write_strobe_n = pins[1].wr_n;
   assign sec_disk_data_out = pins[1].dout;
   assign sec_disk_data_oe = pins[1].doe;
   assign sec_disk_addr = pins[1].addr;
   assign sec_cmd_block_sel_n = pins[1].cmd_sel_n;
   assign sec_ctl_block_sel_n = pins[1].ctl_sel_n;
   assign sec_ctl_block_sel_oe = !pos;

   // ****************************************
   // checks
   // ****************************************
   a_reset_outputs_high: assert property (@(posedge clk) !rst_n |=>
      pri_dma_ack_n && sec_dma_ack_n && pri_cmd_block_sel_n && sec_cmd_block_sel_n
      && pri_ctl_block_sel_n && sec_ctl_block_sel_n)
      else $error("select or acknowledge low after reset");
   a_dma_ack_low: assert property (@(posedge clk) disable iff (!rst_n)
      (state == S_ACT && cur.op != idech_pkg::OP_PIO_RD
       && cur.op != idech_pkg::OP_PIO_WR) |-> !pins[ch].dmack_n)
      else $error("dma strobe without acknowledge");
   a_pio_select: assert property (@(posedge clk) disable iff (!rst_n)
      (state == S_ACT && pins[ch].dmack_n) |-> (pins[ch].cmd_sel_n ^ pins[ch].ctl_sel_n))
      else $error("pio strobe without exactly one select");
   a_pri_cmd_range: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(pri_cmd_block_sel_n) |-> cur.io_addr[15:3] == idech_pkg::PRI_CMD_BASE)
      else $error("primary command select outside its range");
   a_sec_ctl_range: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(sec_ctl_block_sel_n) |-> cur.io_addr[15:3]
      == (split_cfg ? idech_pkg::PRI_CTL_BASE : idech_pkg::SEC_CTL_BASE))
      else $error("secondary control select outside its range");
   a_idle_strobes: assert property (@(posedge clk) disable iff (!rst_n)
      (state == S_IDLE && $past(state) == S_IDLE) |-> pri_read_strobe_n
      && pri_write_strobe_n && sec_read_strobe_n && sec_write_strobe_n)
      else $error("strobe low while idle");
   a_udma_pause: assert property (@(posedge clk) disable iff (!rst_n)
      (state == S_URD && !fifo_in_ready && $past(state) == S_URD) |=>
      (state != S_URD || pins[ch].rd_n))
      else $error("host ready kept low with a full buffer");
   a_uwr_halt: assert property (@(posedge clk) disable iff (!rst_n)
      (state == S_UWR && ready_s) |=> $stable(pins[ch].rd_n))
      else $error("strobe toggled while drive paused");
   a_stop_issue: assert property (@(posedge clk) disable iff (!rst_n)
      (state == S_URD && cmd_valid && cmd_ready) |=> !pins[ch].wr_n [*2])
      else $error("stop not driven after burst end");
   a_pio_stretch: assert property (@(posedge clk) disable iff (!rst_n)
      (state == S_ACT && cnt == 4'h1 && pins[ch].dmack_n && !ready_s) |=> state == S_ACT)
      else $error("pio strobe ended while drive not ready");
endmodule // idech_channel

// [testbench/idech_disk_model.sv]
`timescale 1ns/1ns
// ****************************************
// disk drive stand-in
// ****************************************
module idech_disk_model (
   input wire logic clk,
   input wire logic [1:0] mode,
   input wire logic [3:0] slow,
   input wire logic hold,
   input wire logic [15:0] src,
   input wire logic ack_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [2:0] addr,
   input wire logic cmd_n,
   input wire logic ctl_n,
   input wire logic [15:0] hdata,
   input wire logic hoe,
   output logic ready,
   output logic [15:0] din,
   output logic [21:0] cap,
   output int cap_cnt
);
   logic [15:0] junk = 16'h5a3c;
   logic [15:0] bword = 16'h0000;
   logic bon = 1'b0;
   logic [3:0] cnt = 4'h0;
   wire logic sel = !ack_n || !cmd_n || !ctl_n;
   wire logic pio_out = mode == 2'h0 && !rd_n && sel;
   initial ready = 1'b1;
   initial cap_cnt = 0;
   // a released bus shows a moving pattern, never the last word
   always_comb din = hoe ? hdata : bon ? bword : pio_out ? src : junk;
   always @(posedge clk) begin
      junk <= junk + 16'h3b1d;
      cnt <= (rd_n && wr_n) ? 4'h0 : cnt + 4'(cnt != 4'hf);
      if (mode == 2'h0)
         ready <= (rd_n && wr_n) || cnt >= slow;
      else if (mode == 2'h2)
         ready <= hold;
   end
   always @(posedge wr_n) if (mode == 2'h0 && sel) begin
      cap <= {cmd_n, ctl_n, ack_n, ack_n ? addr : 3'h0, din};
      cap_cnt <= cap_cnt + 1;
   end
   always @(rd_n) if (mode == 2'h2 && !ack_n && wr_n) begin
      cap <= {3'b110, 3'h0, din};
      cap_cnt <= cap_cnt + 1;
   end
   // strobe runs at 400 ns, each half carries one word
   task automatic burst(input int n);
      bon = 1'b1;
      #37;
      for (int k = 0; k < n; k++) begin
         bword = src + 16'(k);
         #100;
         for (int w = 0; w < 40 && rd_n; w++) #50;
         ready = ~ready;
         #100;
      end
      bon = 1'b0;
   endtask
endmodule // idech_disk_model

// [testbench/ide_channel_host_signaling_tb_top.sv]
`timescale 1ns/1ns
// ****************************************
// channel bench
// ****************************************
module ide_channel_host_signaling_tb_top;
   logic clk, rst_n, split_cfg, pos, cmd_valid, cmd_ready, rd_valid, rd_ready, err, busy;
   logic pri_req_level, sec_req_level, p_req, s_req, hold_rd, hold;
   logic p_ack, p_rd, p_wr, p_ready, p_oe, p_cmd, p_ctl, s_ack, s_rd, s_wr, s_ready, s_oe;
   logic s_cmd, s_ctl, s_ctl_oe;
   logic [15:0] rd_data, p_din, p_dout, s_din, s_dout, p_src, s_src, a, d;
   logic [2:0] p_addr, s_addr;
   logic [3:0] slow;
   logic [1:0] mode;
   logic [21:0] p_cap, s_cap, r;
   logic [21:0] exp_p[$], exp_s[$];
   logic [15:0] exp_rd[$];
   logic [15:0] bases[4] = '{16'h01f0, 16'h03f0, 16'h0170, 16'h0370};
   int p_cnt, s_cnt, n, fails = 0, check_count = 0;
   idech_pkg::idech_cmd_t cmd;
   idech_channel dut_u (.clk(clk), .rst_n(rst_n), .split_cfg(split_cfg), .pos(pos), .cmd(cmd),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rd_data(rd_data), .rd_valid(rd_valid),
      .rd_ready(rd_ready), .err(err), .busy(busy), .pri_req_level(pri_req_level),
      .sec_req_level(sec_req_level), .pri_dma_ack_n(p_ack), .pri_dma_req(p_req),
      .pri_read_strobe_n(p_rd), .pri_write_strobe_n(p_wr), .pri_channel_ready(p_ready),
      .pri_disk_data_in(p_din), .pri_disk_data_out(p_dout), .pri_disk_data_oe(p_oe),
      .pri_disk_addr(p_addr), .pri_cmd_block_sel_n(p_cmd), .pri_ctl_block_sel_n(p_ctl),
      .sec_dma_ack_n(s_ack), .sec_dma_req(s_req), .sec_read_strobe_n(s_rd),
      .sec_write_strobe_n(s_wr), .sec_channel_ready(s_ready), .sec_disk_data_in(s_din),
      .sec_disk_data_out(s_dout), .sec_disk_data_oe(s_oe), .sec_disk_addr(s_addr),
      .sec_cmd_block_sel_n(s_cmd), .sec_ctl_block_sel_n(s_ctl), .sec_ctl_block_sel_oe(s_ctl_oe));
   idech_disk_model pm_u (.clk(clk), .mode(mode), .slow(slow), .hold(hold), .src(p_src),
      .ack_n(p_ack), .rd_n(p_rd), .wr_n(p_wr), .addr(p_addr), .cmd_n(p_cmd), .ctl_n(p_ctl),
      .hdata(p_dout), .hoe(p_oe), .ready(p_ready), .din(p_din), .cap(p_cap), .cap_cnt(p_cnt));
   idech_disk_model sm_u (.clk(clk), .mode(mode), .slow(slow), .hold(hold), .src(s_src),
      .ack_n(s_ack), .rd_n(s_rd), .wr_n(s_wr), .addr(s_addr), .cmd_n(s_cmd), .ctl_n(s_ctl),
      .hdata(s_dout), .hoe(s_oe), .ready(s_ready), .din(s_din), .cap(s_cap), .cap_cnt(s_cnt));
   task automatic note(input logic ok, input string what);
      check_count++;
      if (ok !== 1'b1) begin
         fails++;
         $display("wrong value at %0t ns: %s", $time, what);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      note(got === exp, "pin level");
   endtask
   task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
      note(got === exp, "read word");
   endtask
   task automatic cmp_rec(input logic [21:0] got, input logic [21:0] exp);
      note(got === exp, "drive capture");
   endtask
   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic send(input idech_pkg::idech_op_t op, input logic ch, input logic [15:0] ad,
         input logic [15:0] wd, input logic e);
      int k;
      @(negedge clk);
      cmd = '{op: op, chan: ch, io_addr: ad, wdata: wd};
      cmd_valid = 1'b1;
      @(posedge clk);
      for (k = 0; k < 300 && cmd_ready !== 1'b1; k++) @(posedge clk);
      @(negedge clk);
      cmd_valid = 1'b0;
      note(k < 300, "command not taken");
      cmp_bit(err, e);
   endtask
   task automatic wait_idle();
      for (n = 0; n < 100 && busy !== 1'b0; n++) @(negedge clk);
      note(n < 100, "still busy");
   endtask
   task automatic drain();
      for (n = 0; n < 400 && exp_rd.size() != 0; n++) @(negedge clk);
      note(exp_rd.size() == 0, "read words missing");
   endtask
   task automatic end_burst(input logic ch);
      send(idech_pkg::OP_UDMA_END, ch, 16'h0000, 16'h0000, 1'b0);
      for (n = 0; n < 10 && (ch ? s_wr : p_wr) !== 1'b0; n++) @(negedge clk);
      note(n < 10, "no stop seen");
      wait_idle();
   endtask
   task automatic idle_pins();
      cmp_bit(&{p_ack, p_cmd, p_ctl, p_rd, p_wr, s_ack, s_cmd, s_ctl, s_rd, s_wr}, 1'b1);
   endtask
   always @(posedge clk) if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
      note(exp_rd.size() != 0, "extra read word");
      if (exp_rd.size() != 0) cmp_word(rd_data, exp_rd.pop_front());
   end
   always @(p_cnt) if (p_cnt > 0) begin
      note(exp_p.size() != 0, "extra capture");
      if (exp_p.size() != 0) cmp_rec(p_cap, exp_p.pop_front());
   end
   always @(s_cnt) if (s_cnt > 0) begin
      note(exp_s.size() != 0, "extra capture");
      if (exp_s.size() != 0) cmp_rec(s_cap, exp_s.pop_front());
   end
   always @(negedge clk) rd_ready <= !hold_rd && 1'($urandom);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // generous: the whole sequence needs well under a tenth of this
   initial begin
      #3000000;
      fails++;
      complete_run();
   end
   initial begin
      void'($urandom(32'ha7254ecb));
      {rst_n, split_cfg, pos, cmd_valid, rd_ready, hold_rd, p_req, s_req, hold} = '0;
      {cmd, mode, slow, p_src, s_src} = '0;
      repeat (10) @(negedge clk);
      idle_pins();
      rst_n = 1'b1;
      @(negedge clk);
      idle_pins();
      cmp_bit(pri_req_level | sec_req_level, 1'b0);
      pos = 1'b1;
      @(negedge clk);
      cmp_bit(s_ctl_oe, 1'b0);
      idle_pins();
      {pos, p_req, s_req} = 3'b011;
      repeat (3) @(negedge clk);
      cmp_bit(pri_req_level & sec_req_level, 1'b1);
      cmp_bit(s_ctl_oe, 1'b1);
      for (int i = 0; i < 8; i++) begin
         a = bases[i % 4] | 16'($urandom_range(7));
         d = 16'($urandom);
         slow = 4'($urandom_range(7));
         {p_src, s_src} = {d, ~d};
         r = {i[0], !i[0], 1'b1, a[2:0], d};
         if (i < 4) begin
            if (i[1]) exp_s.push_back(r);
            else exp_p.push_back(r);
            send(idech_pkg::OP_PIO_WR, 1'b0, a, d, 1'b0);
         end else begin
            exp_rd.push_back(i[1] ? ~d : d);
            send(idech_pkg::OP_PIO_RD, 1'b0, a, 16'h0000, 1'b0);
         end
         wait_idle();
      end
      slow = 4'h0;
      d = 16'($urandom);
      p_src = d;
      exp_rd.push_back(d);
      send(idech_pkg::OP_DMA_RD, 1'b0, 16'h0000, 16'h0000, 1'b0);
      wait_idle();
      exp_s.push_back({3'b110, 3'h0, ~d});
      send(idech_pkg::OP_DMA_WR, 1'b1, 16'h0000, ~d, 1'b0);
      wait_idle();
      send(idech_pkg::OP_PIO_WR, 1'b0, 16'h0200, d, 1'b1);
      send(idech_pkg::OP_UDMA_END, 1'b0, 16'h0000, d, 1'b1);
      split_cfg = 1'b1;
      exp_s.push_back({3'b011, 3'h2, d});
      send(idech_pkg::OP_PIO_WR, 1'b1, 16'h01f2, d, 1'b0);
      wait_idle();
      send(idech_pkg::OP_PIO_WR, 1'b0, 16'h0172, d, 1'b1);
      split_cfg = 1'b0;
      mode = 2'h2;
      send(idech_pkg::OP_UDMA_WR, 1'b0, 16'h0000, 16'h0000, 1'b0);
      for (int i = 0; i < 2; i++) begin
         d = 16'($urandom);
         exp_p.push_back({3'b110, 3'h0, d});
         hold = i[0];
         repeat (4) @(negedge clk);
         send(idech_pkg::OP_UDMA_WR, 1'b0, 16'h0000, d, 1'b0);
         repeat (10) @(negedge clk);
         cmp_bit(p_rd, 1'b0);
         hold = 1'b0;
         repeat (8) @(negedge clk);
      end
      end_burst(1'b0);
      mode = 2'h0;
      drain();
      mode = 2'h1;
      hold_rd = 1'b1;
      d = 16'($urandom);
      s_src = d;
      send(idech_pkg::OP_UDMA_RD, 1'b1, 16'h0000, 16'h0000, 1'b0);
      repeat (3) @(negedge clk);
      for (int k = 0; k < 4; k++) exp_rd.push_back(d + 16'(k));
      sm_u.burst(4);
      repeat (8) @(negedge clk);
      cmp_bit(s_rd, 1'b1);
      end_burst(1'b1);
      mode = 2'h0;
      hold_rd = 1'b0;
      drain();
      note(exp_p.size() == 0 && exp_s.size() == 0, "captures missing");
      complete_run();
   end
endmodule // ide_channel_host_signaling_tb_top
